/* File: core/bmsa_top.sv */
// top: ahb-lite registers, sequencing and datapath of the bcd math/shift unit
// Operation
// - multiply: low 16 accumulator bits times operand, bcd, up to eight digits
// - multiply/divide operand is a memory word or a 0..9999 bcd constant
// - divide: quotient to accumulator, remainder into first stack level
// - divide raises operand overflow when the operand cannot be handled
// - multiply, divide, increment, decrement set zero flag on zero result
// - multiply and divide set negative flag when result is negative
// - multiply and divide flag any illegal bcd digit they meet
// - a flag holds until the next operation that updates that same flag
// - increment reads a memory word, adds one, writes it back
// - decrement reads a memory word, subtracts one, writes it back
// - shift left moves 32 accumulator bits, zero fill, top bits lost
// - shift count comes from a memory word or a 0..32 constant
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module bmsa_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output bmsa_pkg::bmsa_mem_req_t mem_req_o,
  input wire bmsa_pkg::bmsa_mem_rsp_t mem_rsp_i,
  output bmsa_pkg::bmsa_flags_t flags_o,
  output logic busy_o
);
  import bmsa_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_DIV,
    ST_DIVEND,
    ST_WRITE
  } bmsa_state_t;

  bmsa_state_t state_ff, nxt_state;
  logic dph_wr_ff;
  logic rd_pend_ff;
  logic [ADDR_W-1:0] dph_addr_ff;
  logic [31:0] hrdata_ff;
  logic [2:0] op_ff;
  logic src_mem_ff;
  logic [WORD_W-1:0] cnst_ff;
  logic [WORD_W-1:0] maddr_ff;
  logic [31:0] acc_ff, nxt_acc;
  logic [31:0] stk_ff, nxt_stk;
  bmsa_flags_t flags_ff, nxt_flags;
  logic [WORD_W-1:0] opnd_ff, nxt_opnd;
  logic [WORD_W-1:0] wdat_ff, nxt_wdat;
  logic [BIN8_W-1:0] dvd_ff, nxt_dvd;
  logic [BIN4_W-1:0] rem_ff, nxt_rem;
  logic [BIN4_W-1:0] dvs_ff, nxt_dvs;
  logic [4:0] cnt_ff, nxt_cnt;

  // bus decode: address phase take, data phase register selects
  wire addr_take = hsel & hready & htrans[1];
  wire is_idle = (state_ff == ST_IDLE);
  wire wr_ctrl = dph_wr_ff & (dph_addr_ff == OFS_CTRL);
  wire wr_cnst = dph_wr_ff & (dph_addr_ff == OFS_CONST);
  wire wr_maddr = dph_wr_ff & (dph_addr_ff == OFS_MADDR);
  wire wr_acc = dph_wr_ff & (dph_addr_ff == OFS_ACC);
  wire wr_stk = dph_wr_ff & (dph_addr_ff == OFS_STACK);
  wire [2:0] new_op = hwdata[CTRL_OP_LSB +: CTRL_OP_W];
  wire new_src = hwdata[CTRL_SRC_BIT];
  // starting is the sequencer's decision; a start while busy is dropped
  wire launch = wr_ctrl & is_idle & hwdata[CTRL_START_BIT];
  wire new_incdec = (new_op == BINARY_INCREMENT_OP) | (new_op == BINARY_DECREMENT_OP);
  wire need_mem = new_src | new_incdec;

  // read mux; unmapped offsets read as zero
  wire [31:0] ctrl_rd = {27'h000_0000, src_mem_ff, op_ff, 1'b0};
  wire [31:0] sts_rd = {23'h00_0000, ~is_idle, 4'h0, flags_ff};
  wire [31:0] rd_mux =
    (dph_addr_ff == OFS_CTRL) ? ctrl_rd :
    (dph_addr_ff == OFS_CONST) ? {16'h0000, cnst_ff} :
    (dph_addr_ff == OFS_MADDR) ? {16'h0000, maddr_ff} :
    (dph_addr_ff == OFS_ACC) ? acc_ff :
    (dph_addr_ff == OFS_STACK) ? stk_ff :
    (dph_addr_ff == OFS_STATUS) ? sts_rd : 32'h0000_0000;

  // reads take one wait state so the data comes from a flop and sees a prior write
  assign hreadyout = ce & ~rd_pend_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // bus phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      dph_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      dph_wr_ff <= addr_take & hwrite & (hsize == HSIZE_WORD);
      rd_pend_ff <= addr_take & ~hwrite;
      if (addr_take) begin
        dph_addr_ff <= haddr[ADDR_W-1:0];
      end
      if (rd_pend_ff) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // configuration registers; frozen while an operation runs so its inputs stay put
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_ff <= NO_OP;
      src_mem_ff <= 1'b0;
      cnst_ff <= WORD_RST;
      maddr_ff <= WORD_RST;
    end else if (ce && is_idle) begin
      if (wr_ctrl) begin
        op_ff <= new_op;
        src_mem_ff <= new_src;
      end
      if (wr_cnst) begin
        cnst_ff <= hwdata[WORD_W-1:0];
      end
      if (wr_maddr) begin
        maddr_ff <= hwdata[WORD_W-1:0];
      end
    end
  end

  // operand conversions
  logic [BIN8_W-1:0] acc8_bin;
  logic acc8_bad;
  logic [BIN4_W-1:0] acc4_bin;
  logic acc4_bad;
  logic [BIN4_W-1:0] op4_bin;
  logic op4_bad;
  logic [PROD_W-1:0] res_bin;
  logic [31:0] res_bcd;
  logic [15:0] rem_bcd;

  bmsa_bcd2bin #(.DIGITS(8), .BW(BIN8_W)) u_acc8 (
    .bcd_i(acc_ff),
    .bin_o(acc8_bin),
    .bad_o(acc8_bad)
  );
  bmsa_bcd2bin #(.DIGITS(4), .BW(BIN4_W)) u_acc4 (
    .bcd_i(acc_ff[15:0]),
    .bin_o(acc4_bin),
    .bad_o(acc4_bad)
  );
  bmsa_bcd2bin #(.DIGITS(4), .BW(BIN4_W)) u_opnd (
    .bcd_i(opnd_ff),
    .bin_o(op4_bin),
    .bad_o(op4_bad)
  );

  // one result converter shared by product and quotient
  wire [PROD_W-1:0] prod_bin = PROD_W'(acc4_bin) * PROD_W'(op4_bin);
  assign res_bin = (state_ff == ST_DIVEND) ? PROD_W'(dvd_ff) : prod_bin;

  bmsa_bin2bcd #(.DIGITS(8), .BW(PROD_W)) u_res (
    .bin_i(res_bin),
    .bcd_o(res_bcd)
  );
  bmsa_bin2bcd #(.DIGITS(4), .BW(BIN4_W)) u_rem (
    .bin_i(rem_ff),
    .bcd_o(rem_bcd)
  );

  // restoring divide step, one quotient bit per cycle
  wire [BIN4_W:0] trial = {rem_ff, dvd_ff[BIN8_W-1]};
  wire [BIN4_W+1:0] diff = {1'b0, trial} - {2'b00, dvs_ff};
  wire fits = ~diff[BIN4_W+1];
  wire [BIN4_W-1:0] step_rem = fits ? diff[BIN4_W-1:0] : trial[BIN4_W-1:0];
  wire [BIN8_W-1:0] step_dvd = {dvd_ff[BIN8_W-2:0], fits};

  // increment, decrement and shift results
  wire [WORD_W-1:0] inc_val = opnd_ff + 16'h0001;
  wire [WORD_W-1:0] dec_val = opnd_ff - 16'h0001;
  wire shift_all = (opnd_ff[WORD_W-1:6] != 10'h000) | (opnd_ff[5:0] > SHIFT_MAX);
  wire [31:0] shl_val = shift_all ? 32'h0000_0000 : (acc_ff << opnd_ff[5:0]);
  wire mpy_bad = acc4_bad | op4_bad;
  wire div_bad = acc8_bad | op4_bad;
  wire div_zero = (op4_bin == 15'h0000);

  // sequencing and datapath next state; only flags an operation owns are touched
  always_comb begin
    nxt_state = state_ff;
    nxt_acc = acc_ff;
    nxt_stk = stk_ff;
    nxt_flags = flags_ff;
    nxt_opnd = opnd_ff;
    nxt_wdat = wdat_ff;
    nxt_dvd = dvd_ff;
    nxt_rem = rem_ff;
    nxt_dvs = dvs_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (wr_acc) begin
          nxt_acc = hwdata;
        end
        if (wr_stk) begin
          nxt_stk = hwdata;
        end
        if (launch) begin
          nxt_opnd = cnst_ff;
          nxt_state = need_mem ? ST_FETCH : ST_EXEC;
        end
      end
      ST_FETCH: begin
        if (mem_rsp_i.ack) begin
          nxt_opnd = mem_rsp_i.rdata;
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = ST_IDLE;
        case (op_ff)
          BCD_MULTIPLY_OP: begin
            nxt_acc = res_bcd;
            nxt_flags.zero_result_flag = (res_bcd == 32'h0000_0000);
            nxt_flags.negative_result_flag = res_bcd[31];
            nxt_flags.invalid_bcd_flag = mpy_bad;
          end
          BCD_DIVIDE_OP: begin
            nxt_flags.invalid_bcd_flag = div_bad;
            nxt_flags.operand_overflow_flag = div_zero;
            if (div_zero) begin
              // accumulator kept; its flags describe the value left in place
              nxt_flags.zero_result_flag = (acc_ff == 32'h0000_0000);
              nxt_flags.negative_result_flag = acc_ff[31];
            end else begin
              nxt_dvd = acc8_bin;
              nxt_rem = 15'h0000;
              nxt_dvs = op4_bin;
              nxt_cnt = DIV_LAST;
              nxt_state = ST_DIV;
            end
          end
          BINARY_INCREMENT_OP: begin
            nxt_wdat = inc_val;
            nxt_flags.zero_result_flag = (inc_val == 16'h0000);
            nxt_state = ST_WRITE;
          end
          BINARY_DECREMENT_OP: begin
            nxt_wdat = dec_val;
            nxt_flags.zero_result_flag = (dec_val == 16'h0000);
            nxt_state = ST_WRITE;
          end
          SHIFT_LEFT_OP: begin
            nxt_acc = shl_val;
          end
          default: begin
            nxt_state = ST_IDLE;
          end
        endcase
      end
      ST_DIV: begin
        nxt_dvd = step_dvd;
        nxt_rem = step_rem;
        nxt_cnt = cnt_ff - 5'h01;
        if (cnt_ff == 5'h00) begin
          nxt_state = ST_DIVEND;
        end
      end
      ST_DIVEND: begin
        nxt_acc = res_bcd;
        nxt_stk = {16'h0000, rem_bcd};
        nxt_flags.zero_result_flag = (res_bcd == 32'h0000_0000);
        nxt_flags.negative_result_flag = res_bcd[31];
        nxt_state = ST_IDLE;
      end
      ST_WRITE: begin
        if (mem_rsp_i.ack) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // datapath and state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      acc_ff <= ACC_RST;
      stk_ff <= STACK_RST;
      flags_ff <= '0;
      opnd_ff <= WORD_RST;
      wdat_ff <= WORD_RST;
    end else if (ce) begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      stk_ff <= nxt_stk;
      flags_ff <= nxt_flags;
      opnd_ff <= nxt_opnd;
      wdat_ff <= nxt_wdat;
    end
  end

  // divider working registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dvd_ff <= '0;
      rem_ff <= '0;
      dvs_ff <= '0;
      cnt_ff <= 5'h00;
    end else if (ce) begin
      dvd_ff <= nxt_dvd;
      rem_ff <= nxt_rem;
      dvs_ff <= nxt_dvs;
      cnt_ff <= nxt_cnt;
    end
  end

  // word memory port: request held until the memory acknowledges; one driver for the struct
  assign mem_req_o = '{
    req: (state_ff == ST_FETCH) | (state_ff == ST_WRITE),
    we: (state_ff == ST_WRITE),
    addr: maddr_ff,
    wdata: wdat_ff
  };
  assign flags_o = flags_ff;
  assign busy_o = ~is_idle;
endmodule : bmsa_top
`default_nettype wire

/* File: core/bmsa_pkg.sv */
// package: register map, field layout, op codes and carrier types of the bcd math/shift unit
package bmsa_pkg;
  // register byte offsets, decoded on the low address byte
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONST = 8'h04;
  localparam logic [7:0] OFS_MADDR = 8'h08;
  localparam logic [7:0] OFS_ACC = 8'h0C;
  localparam logic [7:0] OFS_STACK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_SRC_BIT = 4;
  // status register fields
  localparam int STS_FLAG_LSB = 0;
  localparam int STS_BUSY_BIT = 8;
  // operation codes in the control register op field; zero does nothing
  localparam logic [2:0] NO_OP = 3'h0;
  localparam logic [2:0] BCD_MULTIPLY_OP = 3'h1;
  localparam logic [2:0] BCD_DIVIDE_OP = 3'h2;
  localparam logic [2:0] BINARY_INCREMENT_OP = 3'h3;
  localparam logic [2:0] BINARY_DECREMENT_OP = 3'h4;
  localparam logic [2:0] SHIFT_LEFT_OP = 3'h5;
  // reset values
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [31:0] STACK_RST = 32'h0000_0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // datapath widths: 4 and 8 bcd digits, worst case with illegal digits
  localparam int WORD_W = 16;
  localparam int BIN4_W = 15;
  localparam int BIN8_W = 28;
  localparam int PROD_W = 30;
  localparam logic [5:0] SHIFT_MAX = 6'h20;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [4:0] DIV_LAST = 5'h1B;
  // word memory request and answer
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bmsa_mem_req_t;
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } bmsa_mem_rsp_t;
  // status flags, laid out as status bits 3..0
  typedef struct packed {
    logic operand_overflow_flag;
    logic invalid_bcd_flag;
    logic negative_result_flag;
    logic zero_result_flag;
  } bmsa_flags_t;
endpackage : bmsa_pkg

/* File: core/bmsa_bcd2bin.sv */
// bcd to binary converter with illegal digit detection
`timescale 1ns/100ps
`default_nettype none
module bmsa_bcd2bin #(
  parameter int DIGITS = 4,
  parameter int BW = 15
) (
  input wire logic [4*DIGITS-1:0] bcd_i,
  output logic [BW-1:0] bin_o,
  output logic bad_o
);
  // horner sum; illegal digits still weigh in so the result stays defined
  always_comb begin
    bin_o = '0;
    bad_o = 1'b0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      bin_o = BW'(bin_o * BW'(10)) + BW'(bcd_i[4*i +: 4]);
      bad_o = bad_o | (bcd_i[4*i +: 4] > 4'h9);
    end
  end
endmodule : bmsa_bcd2bin
`default_nettype wire

/* File: core/bmsa_bin2bcd.sv */
// binary to bcd converter, shift-and-add-three
`timescale 1ns/100ps
`default_nettype none
module bmsa_bin2bcd #(
  parameter int DIGITS = 8,
  parameter int BW = 30
) (
  input wire logic [BW-1:0] bin_i,
  output logic [4*DIGITS-1:0] bcd_o
);
  // values beyond the digit count lose their top digits
  always_comb begin
    bcd_o = '0;
    for (int b = BW - 1; b >= 0; b--) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (bcd_o[4*d +: 4] > 4'h4) begin
          bcd_o[4*d +: 4] = bcd_o[4*d +: 4] + 4'h3;
        end
      end
      bcd_o = {bcd_o[4*DIGITS-2:0], bin_i[b]};
    end
  end
endmodule : bmsa_bin2bcd
`default_nettype wire

/* File: tb/bmsa_mem_model.sv */
// word memory partner of the bcd math/shift unit, with adjustable answer latency
`timescale 1ns/100ps
`default_nettype none
module bmsa_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire bmsa_pkg::bmsa_mem_req_t req_i,
  output bmsa_pkg::bmsa_mem_rsp_t rsp_o
);
  import bmsa_pkg::*;
  logic [15:0] mem [16];
  logic [3:0] wait_ff;
  logic [15:0] last_ff;
  wire logic ack = req_i.req & (wait_ff == lat);
  // outside the ack cycle the data lines toggle, so stale data never passes as an answer
  assign rsp_o = '{ack: ack, rdata: (ack & ~req_i.we) ? mem[req_i.addr[3:0]] : ~last_ff};
  // wait counter runs while a request stands unanswered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 4'h0;
      last_ff <= WORD_RST;
    end else begin
      wait_ff <= (req_i.req & ~ack) ? wait_ff + 4'h1 : 4'h0;
      last_ff <= rsp_o.rdata;
    end
  end
  // a written word lands on the ack edge; only 16 words, the address is folded
  always @(posedge clk) begin
    if (ack & req_i.we) begin
      mem[req_i.addr[3:0]] <= req_i.wdata;
    end
  end
endmodule : bmsa_mem_model
`default_nettype wire

/* File: tb/bmsa_top_props.sv */
// concurrent checks on the ports of the bcd math/shift unit
`timescale 1ns/100ps
`default_nettype none
module bmsa_top_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire bmsa_pkg::bmsa_mem_req_t mem_req_o,
  input wire bmsa_pkg::bmsa_mem_rsp_t mem_rsp_i,
  input wire bmsa_pkg::bmsa_flags_t flags_o,
  input wire logic busy_o
);
  import bmsa_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] rd_ff;
  logic [15:0] ra_ff;
  wire logic rd_ack = mem_req_o.req & ~mem_req_o.we & mem_rsp_i.ack;
  wire logic wr_req = mem_req_o.req & mem_req_o.we;
  wire logic taken = hsel & hready & htrans[1] & ce;
  // last word read and its address, to judge the write-back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= WORD_RST;
      ra_ff <= WORD_RST;
    end else if (rd_ack) begin
      rd_ff <= mem_rsp_i.rdata;
      ra_ff <= mem_req_o.addr;
    end
  end
  property p_flags_hold;
    !busy_o |=> $stable(flags_o);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags moved while idle");
  property p_req_hold;
    mem_req_o.req && !mem_rsp_i.ack |=> mem_req_o.req && $stable(mem_req_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request dropped before ack");
  property p_wr_addr;
    wr_req |-> mem_req_o.addr == ra_ff;
  endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("write-back address differs from read address");
  property p_wr_data;
    wr_req |-> mem_req_o.wdata == rd_ff + 16'h0001 || mem_req_o.wdata == rd_ff - 16'h0001;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write-back word is not read word plus or minus one");
  property p_wr_zero;
    wr_req |-> flags_o.zero_result_flag == (mem_req_o.wdata == WORD_RST);
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("zero flag does not match written word");
  property p_rd_wait;
    taken && !hwrite |=> !hreadyout ##1 (hreadyout || !ce);
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read data phase not one wait then ready");
  property p_wr_nowait;
    taken && hwrite |=> hreadyout || !ce;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write data phase stalled");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_busy_end;
    $rose(busy_o) |-> ##[1:200] !busy_o;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("operation did not end in time");
endmodule : bmsa_top_props
bind bmsa_top bmsa_top_props props_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i), .flags_o(flags_o), .busy_o(busy_o));
`default_nettype wire

/* File: tb/bcd_math_shift_alu_bench.sv */
// self-checking bench of the bcd math/shift unit with its word memory partner
`timescale 1ns/100ps
`default_nettype none
module bcd_math_shift_alu_bench;
  import bmsa_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] mem_lat = 4'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  bmsa_mem_req_t mem_req;
  bmsa_mem_rsp_t mem_rsp;
  bmsa_flags_t flags;
  logic busy;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // 4 ns period
  always #2 hclk = ~hclk;
  bmsa_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req_o(mem_req),
    .mem_rsp_i(mem_rsp), .flags_o(flags), .busy_o(busy));
  bmsa_mem_model mem_u (.clk(hclk), .rst_n(hresetn), .lat(mem_lat), .req_i(mem_req),
    .rsp_o(mem_rsp));
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // hready is judged at the rising edge, before that edge's flop updates land
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  // loads operands, starts one operation, polls to the end and judges acc, stack and flags
  task automatic op_row(input logic [2:0] op, input logic src, input logic [15:0] m,
      input logic [31:0] acc, input logic [15:0] k, input logic [31:0] eacc,
      input logic [31:0] estk, input logic [3:0] efl);
    logic [31:0] q;
    wr(OFS_ACC, acc);
    wr(OFS_STACK, 32'hFFFF_0000);
    wr(OFS_CONST, {16'h0000, k});
    wr(OFS_MADDR, {16'h0000, m});
    wr(OFS_CTRL, {27'h000_0000, src, op, 1'b1});
    q = 32'hFFFF_FFFF;
    while (q[STS_BUSY_BIT] !== 1'b0) begin
      rd(OFS_STATUS, q);
    end
    chk("status flags", {28'h000_0000, q[3:0]}, {28'h000_0000, efl});
    chk("flag port", {28'h000_0000, flags}, {28'h000_0000, efl});
    rd(OFS_ACC, q);
    chk("acc", q, eacc);
    rd(OFS_STACK, q);
    chk("stack", q, estk);
  endtask : op_row
  // every register reads zero after reset; read-only and unmapped writes leave no trace
  task automatic t_reset;
    logic [31:0] q;
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    wr(8'h18, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), q);
      chk("reset or unmapped word", q, 32'h0000_0000);
    end
  endtask : t_reset
  task automatic t_math;
    op_row(BCD_MULTIPLY_OP, 1'b0, 16'h0000, 32'h5555_1234, 16'h0002, 32'h0000_2468,
      32'hFFFF_0000, 4'h0);
    op_row(BCD_MULTIPLY_OP, 1'b0, 16'h0000, 32'h0000_9999, 16'h9999, 32'h9998_0001,
      32'hFFFF_0000, 4'h2);
    op_row(BCD_MULTIPLY_OP, 1'b0, 16'h0000, 32'h0000_4321, 16'h0000, 32'h0000_0000,
      32'hFFFF_0000, 4'h1);
    op_row(BCD_MULTIPLY_OP, 1'b0, 16'h0000, 32'h0000_000A, 16'h0001, 32'h0000_0010,
      32'hFFFF_0000, 4'h4);
    op_row(BCD_DIVIDE_OP, 1'b0, 16'h0000, 32'h1234_5678, 16'h1000, 32'h0001_2345,
      32'h0000_0678, 4'h0);
    op_row(BCD_DIVIDE_OP, 1'b0, 16'h0000, 32'h0000_0100, 16'h0000, 32'h0000_0100,
      32'hFFFF_0000, 4'h8);
    op_row(BCD_DIVIDE_OP, 1'b0, 16'h0000, 32'h0000_0002, 16'h0003, 32'h0000_0000,
      32'h0000_0002, 4'h1);
  endtask : t_math
  // shifts leave the flags of the last divide alone
  task automatic t_shift;
    op_row(SHIFT_LEFT_OP, 1'b0, 16'h0000, 32'h1234_5678, 16'h0004, 32'h2345_6780,
      32'hFFFF_0000, 4'h1);
    op_row(SHIFT_LEFT_OP, 1'b0, 16'h0000, 32'h8000_0001, 16'h0020, 32'h0000_0000,
      32'hFFFF_0000, 4'h1);
    op_row(SHIFT_LEFT_OP, 1'b0, 16'h0000, 32'h8000_0001, 16'h0000, 32'h8000_0001,
      32'hFFFF_0000, 4'h1);
    op_row(SHIFT_LEFT_OP, 1'b0, 16'h0000, 32'h8000_0001, 16'h001F, 32'h8000_0000,
      32'hFFFF_0000, 4'h1);
  endtask : t_shift
  // memory operands, first with an instant answer, then with a slow one
  task automatic t_mem;
    mem_u.mem[5] = 16'h0000;
    mem_u.mem[6] = 16'hFFFF;
    mem_u.mem[7] = 16'h0003;
    op_row(BINARY_DECREMENT_OP, 1'b1, 16'h0005, 32'h0000_0042, 16'h0000, 32'h0000_0042,
      32'hFFFF_0000, 4'h0);
    chk("decremented word", {16'h0000, mem_u.mem[5]}, 32'h0000_FFFF);
    mem_lat <= 4'h3;
    op_row(BINARY_INCREMENT_OP, 1'b1, 16'h0006, 32'h0000_0042, 16'h0000, 32'h0000_0042,
      32'hFFFF_0000, 4'h1);
    chk("incremented word", {16'h0000, mem_u.mem[6]}, 32'h0000_0000);
    op_row(BCD_MULTIPLY_OP, 1'b1, 16'h0007, 32'h0000_0021, 16'h0000, 32'h0000_0063,
      32'hFFFF_0000, 4'h0);
    op_row(SHIFT_LEFT_OP, 1'b1, 16'h0007, 32'h0000_0001, 16'h0000, 32'h0000_0008,
      32'hFFFF_0000, 4'h0);
  endtask : t_mem
  // clock enable low the cycle after a divide starts, before its first step, freezes the sequencer and stalls the bus
  task automatic t_ce;
    logic [31:0] q;
    wr(OFS_ACC, 32'h0000_0009);
    wr(OFS_CONST, 32'h0000_0002);
    wr(OFS_CTRL, {27'h000_0000, 1'b0, BCD_DIVIDE_OP, 1'b1});
    ce <= 1'b0;
    repeat (40) @(posedge hclk);
    chk("busy frozen by ce", {31'h0000_0000, busy}, 32'h0000_0001);
    chk("ready held low by ce", {31'h0000_0000, hreadyout}, 32'h0000_0000);
    ce <= 1'b1;
    q = 32'hFFFF_FFFF;
    while (q[STS_BUSY_BIT] !== 1'b0) begin
      rd(OFS_STATUS, q);
    end
    chk("flags after ce stall", {28'h000_0000, flags}, 32'h0000_0000);
    rd(OFS_ACC, q);
    chk("acc after ce stall", q, 32'h0000_0004);
    rd(OFS_STACK, q);
    chk("stack after ce stall", q, 32'h0000_0001);
  endtask : t_ce
  // cuts a hang short well after the sequence should have ended
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_math();
    t_shift();
    t_mem();
    t_ce();
    print_verdict();
  end
endmodule : bcd_math_shift_alu_bench
`default_nettype wire
